// ===== arp_pkg.sv
`default_nettype none
package arp_pkg;

   // datapath widths
   localparam int unsigned STATE_W = 128;
   localparam int unsigned OPND_W  = 64;

   // cycles from an accepted request to its result, counted in enabled cycles
   localparam int unsigned LATENCY = 2;

   // column mix coefficients
   localparam logic [7:0] MIX_C2  = 8'h02;
   localparam logic [7:0] MIX_C3  = 8'h03;
   localparam logic [7:0] IMIX_CE = 8'h0e;
   localparam logic [7:0] IMIX_CB = 8'h0b;
   localparam logic [7:0] IMIX_CD = 8'h0d;
   localparam logic [7:0] IMIX_C9 = 8'h09;

   // low byte of x^8+x^4+x^3+x+1, folded back when x^8 appears
   localparam logic [7:0] FIELD_POLY_LOW = 8'h1b;

   // round constant sits in the low byte of operand a
   localparam int unsigned RCON_LSB = 0;
   localparam int unsigned RCON_W   = 8;

   // reset values
   localparam logic [127:0] RESULT_RST = 128'h0;
   localparam logic         VALID_RST  = 1'b0;

   typedef enum logic [3:0] {
      OP_SHIFT_ROWS          = 4'h0,
      OP_INV_SHIFT_ROWS      = 4'h1,
      OP_SUB_BYTES           = 4'h2,
      OP_INV_SUB_BYTES       = 4'h3,
      OP_MIX_COLUMNS         = 4'h4,
      OP_INVERSE_COLUMN_MIX  = 4'h5,
      OP_ROT_WORD            = 4'h6,
      OP_SUB_WORD            = 4'h7,
      OP_ROUND_KEY_ASSIST    = 4'h8,
      OP_CARRYLESS_MUL_64    = 4'h9
   } arp_op_t;

   typedef struct packed {
      logic                valid;
      arp_op_t             op;
      logic [STATE_W-1:0]  state;
      logic [OPND_W-1:0]   opa;
      logic [OPND_W-1:0]   opb;
   } arp_req_t;

endpackage
`default_nettype wire

// ===== arp_sbox.sv
`default_nettype none
module arp_sbox (
   // byte lane
   input  wire logic [7:0] byte_in,
   input  wire logic       inv_in,
   output logic      [7:0] byte_out
);

   // entry 0 sits in the top byte; row = upper nibble, column = lower nibble
   localparam logic [2047:0] FWD_TBL = {
      128'h637c777bf26b6fc53001672bfed7ab76,
      128'hca82c97dfa5947f0add4a2af9ca472c0,
      128'hb7fd9326363ff7cc34a5e5f171d83115,
      128'h04c723c31896059a071280e2eb27b275,
      128'h09832c1a1b6e5aa0523bd6b329e32f84,
      128'h53d100ed20fcb15b6acbbe394a4c58cf,
      128'hd0efaafb434d338545f9027f503c9fa8,
      128'h51a3408f929d38f5bcb6da2110fff3d2,
      128'hcd0c13ec5f974417c4a77e3d645d1973,
      128'h60814fdc222a908846eeb814de5e0bdb,
      128'he0323a0a4906245cc2d3ac629195e479,
      128'he7c8376d8dd54ea96c56f4ea657aae08,
      128'hba78252e1ca6b4c6e8dd741f4bbd8b8a,
      128'h703eb5664803f60e613557b986c11d9e,
      128'he1f8981169d98e949b1e87e9ce5528df,
      128'h8ca1890dbfe6426841992d0fb054bb16
   };

   localparam logic [2047:0] INV_TBL = {
      128'h52096ad53036a538bf40a39e81f3d7fb,
      128'h7ce339829b2fff87348e4344c4dee9cb,
      128'h547b9432a6c2233dee4c950b42fac34e,
      128'h082ea16628d924b2765ba2496d8bd125,
      128'h72f8f66486689816d4a45ccc5d65b692,
      128'h6c704850fdedb9da5e154657a78d9d84,
      128'h90d8ab008cbcd30af7e45805b8b34506,
      128'hd02c1e8fca3f0f02c1afbd0301138a6b,
      128'h3a9111414f67dcea97f2cfcef0b4e673,
      128'h96ac7422e7ad3585e2f937e81c75df6e,
      128'h47f11a711d29c5896fb7620eaa18be1b,
      128'hfc563e4bc6d279209adbc0fe78cd5af4,
      128'h1fdda8338807c731b11210592780ec5f,
      128'h60517fa919b54a0d2de57a9f93c99cef,
      128'ha0e03b4dae2af5b0c8ebbb3c83539961,
      128'h172b047eba77d626e169146355210c7d
   };

   logic [10:0] idx;

   always_comb begin
      idx = 11'h7ff - {byte_in, 3'b000};
      if (inv_in) begin
         byte_out = INV_TBL[idx -: 8];   // see R11
      end else begin
         byte_out = FWD_TBL[idx -: 8];   // see R9 see R10
      end
   end

endmodule
`default_nettype wire

// ===== arp_core.sv
`default_nettype none
// Function
// R1: state handled in little-endian byte order, not standard's textual order.
// R2: S(i,j) is byte 4j+i; column j is word j, row 0 lowest.
// R3: GF(2^8) arithmetic: add is XOR, reduce by x^8+x^4+x^3+x+1.
// R4: byte product: carry-less polynomial multiply, then reduce modulo field.
// R5: forward mix: 02*own ^ 03*next ^ other two, rows cyclic.
// R6: inverse mix: 0e,0b,0d,09 applied to own row then following rows.
// R7: forward row shift: row r rotates left by r byte positions.
// R8: inverse row shift: row r rotates right by r, undoing forward shift.
// R9: substitution per byte; upper nibble row, lower nibble column.
// R10: forward table equals the standard S-box, 00->63, 01->7c.
// R11: inverse table equals inverse S-box, 00->52, 01->09.
// R12: word rotate outputs rows 0,3,2,1 from most to least significant.
// R13: word substitute applies forward table per byte, positions kept.
// R14: 64x64 carry-less multiply, XOR partial products, 128-bit product.
// R15: request with valid strobe; result with valid after fixed latency.
module arp_core (
   // clock and reset
   input  wire logic              core_clk_in,
   input  wire logic              nrst_in,
   input  wire logic              ce_in,
   // request from the pipeline
   input  wire arp_pkg::arp_req_t req_in,
   // result to the pipeline
   output logic                   valid_out,
   output logic [127:0]           result_out
);

   arp_pkg::arp_req_t s1;
   arp_pkg::arp_req_t next_s1;
   logic              next_valid;
   logic [127:0]      next_result;
   logic [127:0]      calc;
   logic [127:0]      sub_out;
   logic              sub_inv;
   logic [31:0]       rcon;
   logic [31:0]       sw1;
   logic [31:0]       sw3;

   // shift-and-reduce per bit is the carry-less product reduced step by step
   function automatic logic [7:0] gf_byte_multiply(input logic [7:0] a,
                                                   input logic [7:0] b);
      logic [7:0] acc;
      logic [7:0] p;
      acc = 8'h00;
      p   = a;
      for (int k = 0; k < 8; k++) begin
         if (b[k]) begin
            acc = acc ^ p;                              // see R3
         end
         p = {p[6:0], 1'b0} ^
             (p[7] ? arp_pkg::FIELD_POLY_LOW : 8'h00);  // see R4
      end
      return acc;
   endfunction

   function automatic logic [127:0] mix_cols(input logic [127:0] s,
                                             input logic         inv);
      logic [7:0]   b [4];
      logic [127:0] o;
      o = 128'h0;
      for (int j = 0; j < 4; j++) begin
         for (int i = 0; i < 4; i++) begin
            b[i] = s[8*(4*j+i) +: 8];                   // see R1 see R2
         end
         for (int i = 0; i < 4; i++) begin
            if (inv) begin
               o[8*(4*j+i) +: 8] =
                  gf_byte_multiply(arp_pkg::IMIX_CE, b[i]) ^
                  gf_byte_multiply(arp_pkg::IMIX_CB, b[(i+1)%4]) ^
                  gf_byte_multiply(arp_pkg::IMIX_CD, b[(i+2)%4]) ^
                  gf_byte_multiply(arp_pkg::IMIX_C9, b[(i+3)%4]); // see R6
            end else begin
               o[8*(4*j+i) +: 8] =
                  gf_byte_multiply(arp_pkg::MIX_C2, b[i]) ^
                  gf_byte_multiply(arp_pkg::MIX_C3, b[(i+1)%4]) ^
                  b[(i+2)%4] ^ b[(i+3)%4];              // see R5
            end
         end
      end
      return o;
   endfunction

   function automatic logic [127:0] shift_rows(input logic [127:0] s,
                                               input logic         inv);
      logic [127:0] o;
      o = 128'h0;
      for (int j = 0; j < 4; j++) begin
         for (int i = 0; i < 4; i++) begin
            if (inv) begin
               o[8*(4*j+i) +: 8] = s[8*(4*((j-i+4)%4)+i) +: 8]; // see R8
            end else begin
               o[8*(4*j+i) +: 8] = s[8*(4*((j+i)%4)+i) +: 8];   // see R7
            end
         end
      end
      return o;
   endfunction

   function automatic logic [31:0] rot_word(input logic [31:0] w);
      return {w[7:0], w[31:24], w[23:16], w[15:8]};    // see R12
   endfunction

   function automatic logic [127:0] carryless_mul_64(input logic [63:0] a,
                                                     input logic [63:0] b);
      logic [127:0] acc;
      acc = 128'h0;
      for (int k = 0; k < 64; k++) begin
         if (b[k]) begin
            acc = acc ^ ({64'h0, a} << k);              // see R14
         end
      end
      return acc;
   endfunction

   // one lookup per byte lane, shared by every substituting operation
   assign sub_inv = (s1.op == arp_pkg::OP_INV_SUB_BYTES);

   for (genvar g = 0; g < 16; g++) begin : g_lane
      arp_sbox u_sbox (
         .byte_in  (s1.state[8*g +: 8]),
         .inv_in   (sub_inv),
         .byte_out (sub_out[8*g +: 8])
      );
   end

   assign rcon = {24'h0, s1.opa[arp_pkg::RCON_LSB +: arp_pkg::RCON_W]};
   assign sw1  = sub_out[63:32];
   assign sw3  = sub_out[127:96];

   always_comb begin
      unique case (s1.op)
         arp_pkg::OP_SHIFT_ROWS:         calc = shift_rows(s1.state, 1'b0);
         arp_pkg::OP_INV_SHIFT_ROWS:     calc = shift_rows(s1.state, 1'b1);
         arp_pkg::OP_SUB_BYTES:          calc = sub_out;      // see R9
         arp_pkg::OP_INV_SUB_BYTES:      calc = sub_out;      // see R11
         arp_pkg::OP_MIX_COLUMNS:        calc = mix_cols(s1.state, 1'b0);
         arp_pkg::OP_INVERSE_COLUMN_MIX: calc = mix_cols(s1.state, 1'b1);
         arp_pkg::OP_ROT_WORD: begin
            calc = {rot_word(s1.state[127:96]), rot_word(s1.state[95:64]),
                    rot_word(s1.state[63:32]), rot_word(s1.state[31:0])};
         end
         arp_pkg::OP_SUB_WORD:           calc = sub_out;      // see R13
         arp_pkg::OP_ROUND_KEY_ASSIST: begin
            calc = {rot_word(sw3) ^ rcon, sw3, rot_word(sw1) ^ rcon, sw1};
         end
         arp_pkg::OP_CARRYLESS_MUL_64: calc = carryless_mul_64(s1.opa, s1.opb);
         // undefined codes return zero rather than stale data
         default:                        calc = 128'h0;
      endcase
   end

   // two enabled edges: capture, then compute and register the result
   always_comb begin
      next_s1     = s1;
      next_valid  = valid_out;
      next_result = result_out;
      if (ce_in) begin
         next_s1    = req_in;
         next_valid = s1.valid;                           // see R15
         if (s1.valid) begin
            next_result = calc;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s1         <= '0;
         valid_out  <= arp_pkg::VALID_RST;
         result_out <= arp_pkg::RESULT_RST;
      end else begin
         s1         <= next_s1;
         valid_out  <= next_valid;
         result_out <= next_result;
      end
   end

   // checks
   latency_valid_a: assert property ( // see R15
      @(posedge core_clk_in) disable iff (!nrst_in)
      (ce_in && req_in.valid) ##1 ce_in |=> valid_out)
      else $error("result valid not raised after two enabled cycles");

   sbox_fwd_a: assert property ( // see R10
      @(posedge core_clk_in) disable iff (!nrst_in)
      (ce_in && s1.valid && s1.op == arp_pkg::OP_SUB_BYTES &&
       s1.state[15:0] == 16'h0100) |=> result_out[15:0] == 16'h7c63)
      else $error("forward substitution of 00 or 01 wrong");

   sbox_inv_a: assert property ( // see R11
      @(posedge core_clk_in) disable iff (!nrst_in)
      (ce_in && s1.valid && s1.op == arp_pkg::OP_INV_SUB_BYTES &&
       s1.state[15:0] == 16'h0100) |=> result_out[15:0] == 16'h0952)
      else $error("inverse substitution of 00 or 01 wrong");

   shift_fwd_a: assert property ( // see R7
      @(posedge core_clk_in) disable iff (!nrst_in)
      (ce_in && s1.valid && s1.op == arp_pkg::OP_SHIFT_ROWS) |=>
      (result_out[15:0] == {$past(s1.state[47:40]), $past(s1.state[7:0])} &&
       result_out[31:24] == $past(s1.state[127:120])))
      else $error("forward row shift misplaced a byte");

   shift_inv_a: assert property ( // see R8
      @(posedge core_clk_in) disable iff (!nrst_in)
      (ce_in && s1.valid && s1.op == arp_pkg::OP_INV_SHIFT_ROWS) |=>
      (result_out[15:8] == $past(s1.state[111:104]) &&
       result_out[31:24] == $past(s1.state[63:56])))
      else $error("inverse row shift misplaced a byte");

   mix_fwd_a: assert property ( // see R5
      @(posedge core_clk_in) disable iff (!nrst_in)
      (ce_in && s1.valid && s1.op == arp_pkg::OP_MIX_COLUMNS &&
       s1.state[31:0] == 32'h00000001) |=> result_out[31:0] == 32'h03010102)
      else $error("forward column mix coefficients wrong");

   mix_inv_a: assert property ( // see R6
      @(posedge core_clk_in) disable iff (!nrst_in)
      (ce_in && s1.valid && s1.op == arp_pkg::OP_INVERSE_COLUMN_MIX &&
       s1.state[31:0] == 32'h00000001) |=> result_out[31:0] == 32'h0b0d090e)
      else $error("inverse column mix coefficients wrong");

   rot_word_a: assert property ( // see R12
      @(posedge core_clk_in) disable iff (!nrst_in)
      (ce_in && s1.valid && s1.op == arp_pkg::OP_ROT_WORD) |=>
      result_out[31:0] == {$past(s1.state[7:0]), $past(s1.state[31:8])})
      else $error("word rotate byte order wrong");

   clmul_unit_a: assert property ( // see R14
      @(posedge core_clk_in) disable iff (!nrst_in)
      (ce_in && s1.valid && s1.op == arp_pkg::OP_CARRYLESS_MUL_64 &&
       s1.opb == 64'h2) |=> result_out == {63'h0, $past(s1.opa), 1'b0})
      else $error("carry-less product by x wrong");

   hold_frozen_a: assert property ( // see R15
      @(posedge core_clk_in) disable iff (!nrst_in)
      !ce_in |=> $stable(result_out) && $stable(valid_out))
      else $error("outputs moved while clock enable low");

   cov_mix_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
      ce_in && s1.valid && s1.op == arp_pkg::OP_INVERSE_COLUMN_MIX);
   cov_clmul_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
      ce_in && s1.valid && s1.op == arp_pkg::OP_CARRYLESS_MUL_64);
   cov_b2b_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
      valid_out ##1 valid_out);

endmodule
`default_nettype wire

// ===== arp_pipe_model.sv
`default_nettype none
module arp_pipe_model (
   // clock and reset
   input  wire logic              core_clk_in,
   input  wire logic              nrst_in,
   // request prepared by the bench
   input  wire arp_pkg::arp_req_t cmd_in,
   // request towards the block
   output var  arp_pkg::arp_req_t req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // no strobe leaves the pipeline while reset holds, so one issued then is dropped
   always_comb begin
      req_out       = cmd_in;
      req_out.valid = cmd_in.valid & nrst_in;
   end
endmodule
`default_nettype wire

// ===== tb_aes_round_primitives.sv
`default_nettype none
module tb_aes_round_primitives;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [127:0] res; int due;} arp_note_t;
   logic              core_clk_in = 1'b0;
   logic              nrst_in     = 1'b0;
   logic              ce_in       = 1'b0;
   arp_pkg::arp_req_t cmd         = '0;
   arp_pkg::arp_req_t req;
   logic              valid_out;
   logic [127:0]      result_out;
   logic [7:0]        sb [256];
   logic [7:0]        isb [256];
   arp_note_t         notes [$];
   int                bad_count = 0;
   int                samples_checked = 0;
   int                ecnt = 0;
   int                cyc = 0;
   logic              en_q = 1'b0;
   logic [31:0]       rng = 32'h0000004c;

   arp_pipe_model pipe (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
                        .cmd_in(cmd), .req_out(req));
   arp_core uut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
                 .ce_in(ce_in), .req_in(req), .valid_out(valid_out),
                 .result_out(result_out));

   always #10 core_clk_in = ~core_clk_in;

   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      p = 8'h00;
      for (int k = 0; k < 8; k++) begin
         if (b[k]) p ^= a;
         a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
      end
      return p;
   endfunction

   function automatic logic [127:0] model(input arp_pkg::arp_req_t q);
      logic [127:0] s, o;
      logic [7:0]   a, n1, n2, n3;
      int           i, w;
      s = q.state;
      o = '0;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            i = 32*c+8*r;
            w = 32*(c|1);
            a = s[i +: 8];
            n1 = s[32*c+8*((r+1)%4) +: 8];
            n2 = s[32*c+8*((r+2)%4) +: 8];
            n3 = s[32*c+8*((r+3)%4) +: 8];
            case (q.op)
               arp_pkg::OP_SHIFT_ROWS: o[i +: 8] = s[32*((c+r)%4)+8*r +: 8];
               arp_pkg::OP_INV_SHIFT_ROWS:
                  o[i +: 8] = s[32*((c+4-r)%4)+8*r +: 8];
               arp_pkg::OP_SUB_BYTES:     o[i +: 8] = sb[a];
               arp_pkg::OP_INV_SUB_BYTES: o[i +: 8] = isb[a];
               arp_pkg::OP_MIX_COLUMNS:
                  o[i +: 8] = gm(8'h02, a) ^ gm(8'h03, n1) ^ n2 ^ n3;
               arp_pkg::OP_INVERSE_COLUMN_MIX: o[i +: 8] = gm(8'h0e, a)
                  ^ gm(8'h0b, n1) ^ gm(8'h0d, n2) ^ gm(8'h09, n3);
               arp_pkg::OP_ROT_WORD: o[i +: 8] = n1;
               arp_pkg::OP_SUB_WORD: o[i +: 8] = sb[a];
               arp_pkg::OP_ROUND_KEY_ASSIST: o[i +: 8] = (c % 2 == 0) ?
                  sb[s[w+8*r +: 8]] : sb[s[w+8*((r+1)%4) +: 8]]
                  ^ ((r == 0) ? q.opa[7:0] : 8'h00);
               default: o[i +: 8] = 8'h00;
            endcase
         end
      end
      if (q.op == arp_pkg::OP_CARRYLESS_MUL_64) begin
         o = '0;
         for (int k = 0; k < 64; k++) begin
            if (q.opb[k]) o ^= {64'h0, q.opa} << k;
         end
      end
      return o;
   endfunction

   task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // the note is taken when the request goes out, due in enabled edges
   task automatic send(input logic [3:0] op, input logic [127:0] s,
                       input logic [63:0] a, input logic [63:0] b,
                       input logic v, input logic e);
      arp_pkg::arp_req_t q;
      @(posedge core_clk_in);
      q = '{valid: v, op: arp_pkg::arp_op_t'(op), state: s, opa: a, opb: b};
      if (v && e) notes.push_back('{model(q),
                                    ecnt + int'(ce_in) + arp_pkg::LATENCY});
      cmd <= q;
      ce_in <= e;
   endtask

   task automatic lit(input logic [3:0] op, input logic [127:0] s,
                      input logic [63:0] a, input logic [63:0] b,
                      input logic [127:0] x);
      send(op, s, a, b, 1'b1, 1'b1);
      notes[$].res = x;
   endtask

   task automatic stop_test();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge core_clk_in) begin
      en_q <= ce_in;
      if (ce_in) ecnt <= ecnt + 1;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         stop_test();
      end
   end

   always @(negedge core_clk_in) begin
      if (nrst_in && en_q && valid_out === 1'b1) begin
         if (notes.size() == 0) begin
            cmp(128'(valid_out), 128'h0);
         end else begin
            cmp(result_out, notes[0].res);
            cmp(128'(ecnt), 128'(notes[0].due));
            void'(notes.pop_front());
         end
      end else if (nrst_in && notes.size() > 0 && notes[0].due <= ecnt) begin
         cmp(128'(valid_out), 128'h1);
         void'(notes.pop_front());
      end
   end

   initial begin
      logic [7:0]   x;
      logic [127:0] s;
      // tables from the field inverse and the affine map
      for (int i = 0; i < 256; i++) begin
         x = 8'h01;
         repeat (254) x = gm(x, 8'(i));
         sb[i] = x ^ {x[6:0], x[7]} ^ {x[5:0], x[7:6]} ^ {x[4:0], x[7:5]}
                 ^ {x[3:0], x[7:4]} ^ 8'h63;
         isb[sb[i]] = 8'(i);
      end
      repeat (16) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      @(negedge core_clk_in);
      cmp(result_out, 128'h0);
      cmp(128'(valid_out), 128'h0);
      $display("test reset done");
      lit(4'h2, 128'h0, 64'h0, 64'h0, {16{8'h63}});
      lit(4'h2, {16{8'h01}}, 64'h0, 64'h0, {16{8'h7c}});
      lit(4'h3, 128'h0, 64'h0, 64'h0, {16{8'h52}});
      lit(4'h3, {16{8'h01}}, 64'h0, 64'h0, {16{8'h09}});
      lit(4'h4, {4{32'h455313db}}, 64'h0, 64'h0, {4{32'hbca14d8e}});
      lit(4'h5, {4{32'hbca14d8e}}, 64'h0, 64'h0, {4{32'h455313db}});
      lit(4'h0, 128'h0f0e0d0c0b0a09080706050403020100, 64'h0, 64'h0,
          128'h0b06010c07020d08030e09040f0a0500);
      lit(4'h1, 128'h0b06010c07020d08030e09040f0a0500, 64'h0, 64'h0,
          128'h0f0e0d0c0b0a09080706050403020100);
      lit(4'h6, 128'h0f0e0d0c0b0a09080706050403020100, 64'h0, 64'h0,
          128'h0c0f0e0d080b0a090407060500030201);
      lit(4'h7, 128'h01, 64'h0, 64'h0, {{15{8'h63}}, 8'h7c});
      lit(4'h9, 128'h0, 64'h3, 64'h3, 128'h5);
      lit(4'h9, 128'h0, {1'b1, 63'h0}, {1'b1, 63'h0},
          {2'b01, 126'h0});
      // single nonzero byte makes each coefficient visible on its own
      lit(4'h4, 128'h1, 64'h0, 64'h0, 128'h03010102);
      lit(4'h5, 128'h1, 64'h0, 64'h0, 128'h0b0d090e);
      lit(4'h9, 128'h0, 64'h8000000000000001, 64'h2,
          128'h00000000000000010000000000000002);
      $display("test known values done");
      for (int k = 0; k < 16; k++) begin
         for (int n = 0; n < 16; n++) s[8*n +: 8] = 8'(16*k+n);
         send(4'h2, s, 64'h0, 64'h0, 1'b1, 1'b1);
         send(4'h3, s, 64'h0, 64'h0, 1'b1, 1'b1);
         send(4'h7, s, 64'h0, 64'h0, 1'b1, 1'b1);
      end
      $display("test full tables done");
      // random ops, undefined codes included, with stalls and gaps
      repeat (400) begin
         send(4'(rnd()), {rnd(), rnd(), rnd(), rnd()}, {rnd(), rnd()},
              {rnd(), rnd()}, rnd() % 4 != 0, rnd() % 4 != 0);
      end
      repeat (8) send(4'h0, 128'h0, 64'h0, 64'h0, 1'b0, 1'b1);
      cmp(128'(notes.size()), 128'h0);
      $display("test random stream done");
      send(4'h9, 128'h0, 64'h5, 64'h7, 1'b1, 1'b1);
      send(4'h0, 128'h0, 64'h0, 64'h0, 1'b0, 1'b1);
      nrst_in <= 1'b0;
      notes.delete();
      @(negedge core_clk_in);
      cmp(result_out, 128'h0);
      cmp(128'(valid_out), 128'h0);
      repeat (2) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      lit(4'h9, 128'h0, 64'h5, 64'h7, 128'h1b);
      repeat (4) send(4'h0, 128'h0, 64'h0, 64'h0, 1'b0, 1'b1);
      cmp(128'(notes.size()), 128'h0);
      $display("test second reset done");
      stop_test();
   end
endmodule
`default_nettype wire
